// File: rtl/linear11_ticks.v
// Converts a linear-11 delay word in milliseconds to a count of delay steps
`default_nettype none
`include "pg_delay_consts.vh"

module linear11_ticks #(
	parameter TICK_W = 22
)(
	input  wire [15:0]       delay_word,
	output reg  [TICK_W-1:0] delay_ticks
);
	localparam STEPS_INT = `NS_PER_MS / `PG_STEP_NS;
	localparam MAX_INT   = `PG_MAX_MS * STEPS_INT;
	localparam [12:0] STEPS_PER_MS = STEPS_INT[12:0];
	localparam [39:0] MAX_TICKS    = {8'h00, MAX_INT[31:0]};

	wire signed [4:0]  exp_n   = delay_word[`L11_EXP_MSB:`L11_EXP_LSB];
	wire               mant_neg = delay_word[`L11_MANT_MSB];
	wire [22:0]        prod    = delay_word[`L11_MANT_MSB-1:0] * STEPS_PER_MS;
	reg  [39:0]        wide;

	always @*
	begin
		// Negative mantissa means no sensible delay; treat as zero
		if (mant_neg)
			wide = 40'h0;
		else if (exp_n[4])
			wide = {17'h0, prod} >> (5'd0 - exp_n);
		else
			wide = {17'h0, prod} << exp_n;
		// Saturate at the top of the range rather than wrap
		if (wide > MAX_TICKS)
			delay_ticks = MAX_TICKS[TICK_W-1:0];
		else
			delay_ticks = wide[TICK_W-1:0];
	end
endmodule
`default_nettype wire

// File: rtl/output_ok_timer.v
// Per-output qualification timer that raises output ok after the programmed delay
`default_nettype none

module output_ok_timer #(
	parameter TICK_W = 22
)(
	input  wire              mclk,
	input  wire              rst_b,
	input  wire              step_tick,
	input  wire              above_thresh,
	input  wire [TICK_W-1:0] delay_ticks,
	output reg               output_ok_r
);
	reg [TICK_W-1:0] count_r;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_r     <= {TICK_W{1'b0}};
			output_ok_r <= 1'b0;
		end
		else if (!above_thresh)
		begin
			// Any dip restarts qualification from zero
			count_r     <= {TICK_W{1'b0}};
			output_ok_r <= 1'b0;
		end
		else if (!output_ok_r)
		begin
			if (count_r >= delay_ticks)
				output_ok_r <= 1'b1;
			else if (step_tick)
				count_r <= count_r + {{(TICK_W-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// File: rtl/pg_delay_ramp_and_fault_masks.v
// Power-good delay, start-up ramp-gain mode and fault mask command bank
// Function
// - Output ok rises only after the configured delay above the threshold.
// - Delay spans zero to 500 ms in 125 ns steps.
// - Delay word is linear-11 milliseconds; reset BA00h equals 1 ms.
// - Each output page holds its own independent delay word.
// - Ramp-gain mode is entered automatically in a four-phase group.
// - Ramp-gain mode holds fast compensation off until output ok.
// - Ramp-gain mode allows no soft-off and ignores turn-off fall time.
// - Ramp-gain shutdown tri-states high-side drive and pulls low-side low.
// - Standalone keeps compensation on and rise, fall, soft-off normal.
// - Ramp gain is one global 8-bit value, reset 03h.
// - Rise time is output command over 14, input, frequency, gain.
// - Set capture mask bits suppress capture event and store; reset 0000h.
// - Capture mask bits 0-7 and 10-13 map fault types; others unused.
// - Set alert mask bits stop the matching status fault asserting alert.
// - Alert mask is seven bytes, reset all zeros.
// - Summary byte bits mask voltage, current, input, temperature, comms, mfr.
`default_nettype none
`include "pg_delay_consts.vh"

module pg_delay_ramp_and_fault_masks #(
	parameter PAGES  = 2,
	parameter TICK_W = 22
)(
	input  wire                mclk,
	input  wire                rst_b,
	// Command port from the management bus engine
	input  wire                cmd_valid,
	input  wire                cmd_write,
	input  wire [7:0]          cmd_code,
	input  wire                cmd_page,
	input  wire [55:0]         cmd_wdata,
	output reg                 rsp_ack_r,
	output reg                 rsp_err_r,
	output reg  [55:0]         rsp_rdata_r,
	// Converter state
	input  wire [PAGES-1:0]    vout_above_pg,
	input  wire                four_phase_group,
	input  wire [PAGES-1:0]    shutdown_cmd,
	input  wire [PAGES-1:0]    pwm_high_in,
	input  wire [PAGES-1:0]    pwm_low_in,
	input  wire [15:0]         vin_code,
	input  wire [11:0]         fsw_code,
	input  wire [15:0]         fault_event,
	input  wire [55:0]         status_bytes,
	// Outputs
	output reg  [PAGES-1:0]    output_ok_pin,
	output reg  [PAGES-1:0]    fast_loop_compensation,
	output reg                 ramp_gain_mode_r,
	output reg                 soft_off_allow_r,
	output reg                 turnoff_fall_time_en_r,
	output reg                 turnon_rise_time_en_r,
	output reg  [39:0]         ramp_slope_r,
	output reg  [PAGES-1:0]    high_side_drive_out,
	output reg  [PAGES-1:0]    high_side_drive_oe,
	output reg  [PAGES-1:0]    low_side_drive_out,
	output reg                 capture_event_r,
	output reg                 capture_store_r,
	output reg                 alert_pin_out,
	output reg                 alert_pin_oe
);
	// Step divider: 20 ns clocks accumulate against the 125 ns step so the mean step is
	// exact; single steps last 6 or 7 cycles, and the clock must stay faster than a step
	localparam STEP_NS_INT = `PG_STEP_NS;
	localparam CLK_NS_INT  = `MCLK_PERIOD_NS;
	localparam [7:0] STEP_NS = STEP_NS_INT[7:0];
	localparam [7:0] CLK_NS  = CLK_NS_INT[7:0];
	localparam [7:0] WRAP_AT = STEP_NS - CLK_NS;

	reg  [7:0]          step_acc_r;
	reg                 step_tick_r;
	reg  [PAGES-1:0]    above_meta_r;
	reg  [PAGES-1:0]    above_sync_r;
	reg  [15:0]         delay_word_r [0:PAGES-1];
	reg  [7:0]          startup_ramp_gain_r;
	reg  [15:0]         capture_fault_mask_r;
	reg  [55:0]         alert_fault_mask_r;
	reg  [55:0]         rdata_nxt;
	reg                 err_nxt;
	wire [PAGES-1:0]    ok_raw;
	wire [15:0]         capture_hits;
	wire [55:0]         alert_hits;
	wire [39:0]         slope_nxt;
	wire [PAGES-1:0]    page_hot;
	wire                cmd_wr;

	// One-cycle step enable, 125 ns apart on average
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			step_acc_r  <= 8'h00;
			step_tick_r <= 1'b0;
		end
		else if (step_acc_r >= WRAP_AT)
		begin
			step_acc_r  <= step_acc_r + CLK_NS - STEP_NS;
			step_tick_r <= 1'b1;
		end
		else
		begin
			step_acc_r  <= step_acc_r + CLK_NS;
			step_tick_r <= 1'b0;
		end
	end

	// Comparator levels come from the analog side, so they are synchronised first
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			above_meta_r <= {PAGES{1'b0}};
			above_sync_r <= {PAGES{1'b0}};
		end
		else
		begin
			above_meta_r <= vout_above_pg;
			above_sync_r <= above_meta_r;
		end
	end

	// Page select decoded once so each page tests one bit, not the page number
	assign cmd_wr   = cmd_valid && cmd_write;
	assign page_hot = {{(PAGES-1){1'b0}}, 1'b1} << cmd_page;

	// Per-page delay word, converter and timer
	genvar p;
	generate
		for (p = 0; p < PAGES; p = p + 1)
		begin : page
			wire [TICK_W-1:0] ticks;

			always @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
					delay_word_r[p] <= `RST_OUTPUT_OK_ASSERT_DELAY;
				else if (cmd_wr && page_hot[p]
					&& cmd_code == `CMD_OUTPUT_OK_ASSERT_DELAY)
					delay_word_r[p] <= cmd_wdata[15:0];
			end

			linear11_ticks #(
				.TICK_W      (TICK_W)
			) conv (
				.delay_word  (delay_word_r[p]),
				.delay_ticks (ticks)
			);

			output_ok_timer #(
				.TICK_W       (TICK_W)
			) timer (
				.mclk         (mclk),
				.rst_b        (rst_b),
				.step_tick    (step_tick_r),
				.above_thresh (above_sync_r[p]),
				.delay_ticks  (ticks),
				.output_ok_r  (ok_raw[p])
			);

			// Power stage drive and compensation per output
			always @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					output_ok_pin[p]          <= 1'b0;
					fast_loop_compensation[p] <= 1'b1;
					high_side_drive_out[p]    <= 1'b0;
					high_side_drive_oe[p]     <= 1'b0;
					low_side_drive_out[p]     <= 1'b0;
				end
				else
				begin
					output_ok_pin[p] <= ok_raw[p];
					// Ramp mode keeps the wide loop off until the output qualifies
					fast_loop_compensation[p] <= !ramp_gain_mode_r || ok_raw[p];
					if (ramp_gain_mode_r && shutdown_cmd[p])
					begin
						// Hard stop: no soft-off ramp exists in this mode
						high_side_drive_out[p] <= 1'b0;
						high_side_drive_oe[p]  <= 1'b0;
						low_side_drive_out[p]  <= 1'b0;
					end
					else
					begin
						high_side_drive_out[p] <= pwm_high_in[p];
						high_side_drive_oe[p]  <= 1'b1;
						low_side_drive_out[p]  <= pwm_low_in[p];
					end
				end
			end
		end
	endgenerate

	// Global registers
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			startup_ramp_gain_r  <= `RST_STARTUP_RAMP_GAIN;
			capture_fault_mask_r <= `RST_CAPTURE_FAULT_MASK;
			alert_fault_mask_r   <= `RST_ALERT_FAULT_MASK;
		end
		else if (cmd_wr)
		begin
			case (cmd_code)
				`CMD_STARTUP_RAMP_GAIN:
					startup_ramp_gain_r <= cmd_wdata[7:0];
				`CMD_CAPTURE_FAULT_MASK:
					capture_fault_mask_r <= cmd_wdata[15:0] & `CAPTURE_MASK_USED;
				`CMD_ALERT_FAULT_MASK:
					alert_fault_mask_r <= cmd_wdata & `ALERT_MASK_USED;
				default:
					startup_ramp_gain_r <= startup_ramp_gain_r;
			endcase
		end
	end

	// Read mux; unknown codes answer with an error and zero data
	always @*
	begin
		rdata_nxt = 56'h0;
		err_nxt   = 1'b0;
		case (cmd_code)
			`CMD_OUTPUT_OK_ASSERT_DELAY:
				rdata_nxt[15:0] = delay_word_r[cmd_page];
			`CMD_STARTUP_RAMP_GAIN:
				rdata_nxt[7:0] = startup_ramp_gain_r;
			`CMD_CAPTURE_FAULT_MASK:
				rdata_nxt[15:0] = capture_fault_mask_r;
			`CMD_ALERT_FAULT_MASK:
				rdata_nxt = alert_fault_mask_r;
			default:
				err_nxt = 1'b1;
		endcase
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rsp_ack_r   <= 1'b0;
			rsp_err_r   <= 1'b0;
			rsp_rdata_r <= 56'h0;
		end
		else
		begin
			rsp_ack_r <= cmd_valid;
			rsp_err_r <= cmd_valid && err_nxt;
			if (cmd_valid && !cmd_write)
				rsp_rdata_r <= rdata_nxt;
		end
	end

	// Mode selection and rise-rate; slope is the divisor of the output command
	assign slope_nxt = `RAMP_EQ_FACTOR * vin_code * fsw_code * startup_ramp_gain_r;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ramp_gain_mode_r       <= 1'b0;
			soft_off_allow_r       <= 1'b1;
			turnoff_fall_time_en_r <= 1'b1;
			turnon_rise_time_en_r  <= 1'b1;
			ramp_slope_r           <= 40'h0;
		end
		else
		begin
			ramp_gain_mode_r       <= four_phase_group;
			soft_off_allow_r       <= !four_phase_group;
			turnoff_fall_time_en_r <= !four_phase_group;
			// Rise time is set by the gain slope instead of the turn-on time
			turnon_rise_time_en_r  <= !four_phase_group;
			ramp_slope_r           <= slope_nxt;
		end
	end

	// Fault masking: capture and alert
	assign capture_hits = fault_event & ~capture_fault_mask_r & `CAPTURE_MASK_USED;
	assign alert_hits   = status_bytes & ~alert_fault_mask_r;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			capture_event_r <= 1'b0;
			capture_store_r <= 1'b0;
		end
		else
		begin
			capture_event_r <= |capture_hits;
			capture_store_r <= |capture_hits;
		end
	end

	// Open drain: only ever pulls low, so the level is fixed and the enable carries the alert
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			alert_pin_out <= 1'b0;
			alert_pin_oe  <= 1'b0;
		end
		else
		begin
			alert_pin_out <= 1'b0;
			alert_pin_oe  <= |alert_hits;
		end
	end
endmodule
`default_nettype wire

// File: shared/pg_delay_consts.vh
// Command codes, reset values, field layouts and timing for the power-good and mask bank
`ifndef PG_DELAY_CONSTS_VH
`define PG_DELAY_CONSTS_VH

`define CMD_OUTPUT_OK_ASSERT_DELAY 8'hD4
`define CMD_STARTUP_RAMP_GAIN      8'hD5
`define CMD_CAPTURE_FAULT_MASK     8'hD7
`define CMD_ALERT_FAULT_MASK       8'hDB

`define RST_OUTPUT_OK_ASSERT_DELAY 16'hBA00
`define RST_STARTUP_RAMP_GAIN      8'h03
`define RST_CAPTURE_FAULT_MASK     16'h0000
`define RST_ALERT_FAULT_MASK       56'h00000000000000

// Writable bits: unused capture bits 8, 9, 14, 15 and summary bit 5 read as zero
`define CAPTURE_MASK_USED          16'h3CFF
`define ALERT_MASK_USED            56'hFFFFFFFFFFFFDF

// Linear-11 field layout
`define L11_EXP_MSB                15
`define L11_EXP_LSB                11
`define L11_MANT_MSB               10

// Delay timing: step size, range and clock period
`define PG_STEP_NS                 125
`define PG_MAX_MS                  500
`define NS_PER_MS                  1000000
`define MCLK_PERIOD_NS             20

// Rise-time equation constant
`define RAMP_EQ_FACTOR             4'hE

`endif

// File: test/mgmt_host.sv
// Management bus host model driving the command port
`default_nettype none
module mgmt_host (
	input  wire logic        mclk,
	output var  logic        cmd_valid,
	output var  logic        cmd_write,
	output var  logic [7:0]  cmd_code,
	output var  logic        cmd_page,
	output var  logic [55:0] cmd_wdata,
	input  wire logic        rsp_ack_r,
	input  wire logic        rsp_err_r,
	input  wire logic [55:0] rsp_rdata_r
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_page  = 1'b0;
		cmd_wdata = 56'h0;
	end
	// Short delays are legal but give no debounce; only the bench uses them
	// Idle code and data are inverted so a stale command never looks current
	task automatic xfer(input logic w, input logic [7:0] c, input logic p,
		input logic [55:0] d, output logic [57:0] r);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_code  <= c;
		cmd_page  <= p;
		cmd_wdata <= d;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_code  <= ~c;
		cmd_wdata <= ~d;
		@(posedge mclk);
		r = {rsp_ack_r, rsp_err_r, rsp_rdata_r};
	endtask
endmodule
`default_nettype wire

// File: test/pg_bank_chk_sva.sv
// Concurrent checks on the power-good, ramp-mode and fault mask bank
`default_nettype none
`include "pg_delay_consts.vh"
module pg_bank_chk #(
	parameter PAGES = 2
)(
	input wire logic             mclk,
	input wire logic             rst_b,
	input wire logic [PAGES-1:0] vout_above_pg,
	input wire logic             four_phase_group,
	input wire logic [PAGES-1:0] shutdown_cmd,
	input wire logic [15:0]      fault_event,
	input wire logic [55:0]      status_bytes,
	input wire logic [PAGES-1:0] output_ok_pin,
	input wire logic [PAGES-1:0] fast_loop_compensation,
	input wire logic             ramp_gain_mode_r,
	input wire logic             soft_off_allow_r,
	input wire logic             turnoff_fall_time_en_r,
	input wire logic             turnon_rise_time_en_r,
	input wire logic [PAGES-1:0] high_side_drive_oe,
	input wire logic [PAGES-1:0] low_side_drive_out,
	input wire logic             capture_event_r,
	input wire logic             alert_pin_out,
	input wire logic             alert_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_ok_rise;
		$rose(output_ok_pin[0]) |-> $past(vout_above_pg[0], 4);
	endproperty
	a_ok_rise: assert property (p_ok_rise) else $error("ok rose, input low");
	property p_ok_drop;
		!vout_above_pg[0] [*6] |-> !output_ok_pin[0];
	endproperty
	a_ok_drop: assert property (p_ok_drop) else $error("ok stayed high");
	property p_mode;
		1'b1 |=> ramp_gain_mode_r == $past(four_phase_group);
	endproperty
	a_mode: assert property (p_mode) else $error("ramp mode mismatch");
	property p_comp_off;
		(ramp_gain_mode_r && !output_ok_pin[0]) [*2] |-> !fast_loop_compensation[0];
	endproperty
	a_comp_off: assert property (p_comp_off) else $error("comp on in ramp");
	property p_no_softoff;
		ramp_gain_mode_r [*2] |-> !soft_off_allow_r && !turnoff_fall_time_en_r;
	endproperty
	a_no_softoff: assert property (p_no_softoff) else $error("soft-off in ramp");
	property p_stop;
		ramp_gain_mode_r && shutdown_cmd[0] |=> !high_side_drive_oe[0] && !low_side_drive_out[0];
	endproperty
	a_stop: assert property (p_stop) else $error("drive not off");
	property p_alone;
		!ramp_gain_mode_r [*2] |-> &fast_loop_compensation && soft_off_allow_r
			&& turnoff_fall_time_en_r && turnon_rise_time_en_r;
	endproperty
	a_alone: assert property (p_alone) else $error("standalone not normal");
	property p_capt;
		capture_event_r |-> |($past(fault_event) & `CAPTURE_MASK_USED);
	endproperty
	a_capt: assert property (p_capt) else $error("capture without fault");
	property p_alert;
		alert_pin_oe |-> |$past(status_bytes) && !alert_pin_out;
	endproperty
	a_alert: assert property (p_alert) else $error("alert without status");
endmodule
bind pg_delay_ramp_and_fault_masks pg_bank_chk #(.PAGES(PAGES)) chk (.mclk, .rst_b,
	.vout_above_pg, .four_phase_group, .shutdown_cmd, .fault_event, .status_bytes,
	.output_ok_pin, .fast_loop_compensation, .ramp_gain_mode_r, .soft_off_allow_r,
	.turnoff_fall_time_en_r, .turnon_rise_time_en_r, .high_side_drive_oe,
	.low_side_drive_out, .capture_event_r, .alert_pin_out, .alert_pin_oe);
`default_nettype wire

// File: test/tb_pg_delay_ramp_and_fault_masks.sv
// Self-checking bench for the power-good, ramp-mode and fault mask bank
`default_nettype none
`include "pg_delay_consts.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_pg_delay_ramp_and_fault_masks;
	timeunit 1ns;
	timeprecision 1ps;
	// Fifteen 125 ns steps at 20 ns a cycle, widened by sync, timer and step phase
	localparam int STEPS = 15;
	localparam int LO    = STEPS * `PG_STEP_NS / `MCLK_PERIOD_NS - 1;
	localparam int HI    = STEPS * `PG_STEP_NS / `MCLK_PERIOD_NS + 8;
	localparam logic [15:0] USED = `CAPTURE_MASK_USED;
	logic        mclk = 1'b0, rst_b = 1'b0, four_phase_group = 1'b0;
	logic [1:0]  vout_above_pg = 2'h0, shutdown_cmd = 2'h0, pwm_high_in = 2'h3, pwm_low_in = 2'h3;
	logic [15:0] vin_code = 16'h0002, fault_event = 16'h0;
	logic [11:0] fsw_code = 12'h003;
	logic [55:0] status_bytes = 56'h0, cmd_wdata, rsp_rdata_r;
	logic [7:0]  cmd_code;
	logic [39:0] ramp_slope_r;
	logic [57:0] r;
	logic [1:0]  output_ok_pin, fast_loop_compensation, high_side_drive_out, high_side_drive_oe;
	logic [1:0]  low_side_drive_out;
	logic        cmd_valid, cmd_write, cmd_page, rsp_ack_r, rsp_err_r, ramp_gain_mode_r;
	logic        soft_off_allow_r, turnoff_fall_time_en_r, turnon_rise_time_en_r;
	logic        capture_event_r, capture_store_r, alert_pin_out, alert_pin_oe;
	int          fails = 0, num_checks = 0, n0, n1;
	always #10 mclk = ~mclk;
	mgmt_host host (.mclk, .cmd_valid, .cmd_write, .cmd_code, .cmd_page, .cmd_wdata,
		.rsp_ack_r, .rsp_err_r, .rsp_rdata_r);
	pg_delay_ramp_and_fault_masks dut (.mclk, .rst_b, .cmd_valid, .cmd_write, .cmd_code,
		.cmd_page, .cmd_wdata, .rsp_ack_r, .rsp_err_r, .rsp_rdata_r, .vout_above_pg,
		.four_phase_group, .shutdown_cmd, .pwm_high_in, .pwm_low_in, .vin_code, .fsw_code,
		.fault_event, .status_bytes, .output_ok_pin, .fast_loop_compensation, .ramp_gain_mode_r,
		.soft_off_allow_r, .turnoff_fall_time_en_r, .turnon_rise_time_en_r, .ramp_slope_r,
		.high_side_drive_out, .high_side_drive_oe, .low_side_drive_out, .capture_event_r,
		.capture_store_r, .alert_pin_out, .alert_pin_oe);
	task automatic wr(input logic [7:0] c, input logic p, input logic [55:0] d);
		host.xfer(1'b1, c, p, d, r);
	endtask
	task automatic rd(input logic [7:0] c, input logic p);
		host.xfer(1'b0, c, p, 56'h0, r);
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// Bounded wait so a stuck timer cannot hang the run
	task automatic wait_ok(input int pg, output int n);
		n = 0;
		while (output_ok_pin[pg] !== 1'b1 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic t_regs;
		logic [7:0]  c[4] = '{`CMD_OUTPUT_OK_ASSERT_DELAY, `CMD_STARTUP_RAMP_GAIN,
			`CMD_CAPTURE_FAULT_MASK, `CMD_ALERT_FAULT_MASK};
		logic [55:0] v[4] = '{56'hBA00, 56'h03, 56'h0, 56'h0};
		for (int i = 0; i < 4; i++)
		begin
			rd(c[i], 1'b1);
			`CHK("reset value", {2'h2, v[i]}, r)
		end
		wr(`CMD_OUTPUT_OK_ASSERT_DELAY, 1'b1, 56'hB801);
		rd(`CMD_OUTPUT_OK_ASSERT_DELAY, 1'b0);
		`CHK("page0 delay", {2'h2, 56'hBA00}, r)
		rd(`CMD_OUTPUT_OK_ASSERT_DELAY, 1'b1);
		`CHK("page1 delay", {2'h2, 56'hB801}, r)
		wr(`CMD_CAPTURE_FAULT_MASK, 1'b0, 56'hFFFF);
		rd(`CMD_CAPTURE_FAULT_MASK, 1'b0);
		`CHK("capture mask", {2'h2, 56'h3CFF}, r)
		wr(`CMD_ALERT_FAULT_MASK, 1'b0, 56'hFFFFFFFFFFFFFF);
		rd(`CMD_ALERT_FAULT_MASK, 1'b0);
		`CHK("alert mask", {2'h2, 56'hFFFFFFFFFFFFDF}, r)
		wr(8'hD6, 1'b0, 56'hFF);
		rd(8'hD6, 1'b0);
		`CHK("unknown code", {2'h3, 56'h0}, r)
		rd(`CMD_STARTUP_RAMP_GAIN, 1'b0);
		`CHK("gain kept", {2'h2, 56'h03}, r)
		$display("t_regs done");
	endtask
	task automatic t_pgood;
		wr(`CMD_OUTPUT_OK_ASSERT_DELAY, 1'b0, 56'h0);
		vout_above_pg <= 2'h3;
		wait_ok(0, n0);
		`CHK("zero delay", 1'b1, n0 <= 8)
		`CHK("page1 still low", 1'b0, output_ok_pin[1])
		wait_ok(1, n1);
		`CHK("short delay", 1'b1, n0 + n1 >= LO && n0 + n1 <= HI)
		vout_above_pg <= 2'h1;
		wt(6);
		`CHK("ok dropped", 1'b0, output_ok_pin[1])
		vout_above_pg <= 2'h3;
		wt(60);
		vout_above_pg <= 2'h1;
		wt(2);
		vout_above_pg <= 2'h3;
		wait_ok(1, n1);
		`CHK("restart", 1'b1, n1 >= LO && n1 <= HI)
		vout_above_pg <= 2'h0;
		wt(8);
		$display("t_pgood done");
	endtask
	task automatic t_ramp;
		wr(`CMD_STARTUP_RAMP_GAIN, 1'b0, 56'h05);
		four_phase_group <= 1'b1;
		shutdown_cmd <= 2'h1;
		wt(4);
		`CHK("comp off", 2'h0, fast_loop_compensation)
		`CHK("ramp flags", 4'h8, {ramp_gain_mode_r, soft_off_allow_r,
			turnoff_fall_time_en_r, turnon_rise_time_en_r});
		`CHK("drive", 4'hA, {high_side_drive_oe, low_side_drive_out})
		`CHK("slope", 40'h1A4, ramp_slope_r)
		vout_above_pg <= 2'h1;
		wt(12);
		`CHK("comp after ok", 2'h1, fast_loop_compensation)
		four_phase_group <= 1'b0;
		shutdown_cmd <= 2'h0;
		vout_above_pg <= 2'h0;
		wt(4);
		`CHK("standalone", 5'h1F, {fast_loop_compensation, soft_off_allow_r,
			turnoff_fall_time_en_r, turnon_rise_time_en_r});
		`CHK("pass drive", 2'h3, high_side_drive_out & high_side_drive_oe)
		$display("t_ramp done");
	endtask
	task automatic t_faults;
		for (int i = 0; i < 16; i++)
			for (int m = 0; m < 2; m++)
			begin
				wr(`CMD_CAPTURE_FAULT_MASK, 1'b0, m ? (56'h1 << i) : 56'h0);
				fault_event <= 16'h1 << i;
				@(posedge mclk);
				fault_event <= 16'h0;
				@(posedge mclk);
				`CHK("capture", (!m && USED[i]) ? 2'h3 : 2'h0,
					{capture_event_r, capture_store_r});
			end
		for (int i = 0; i < 56; i++)
		begin
			wr(`CMD_ALERT_FAULT_MASK, 1'b0, 56'h1 << i);
			status_bytes <= 56'h1 << i;
			wt(2);
			`CHK("alert masked", i == 5, alert_pin_oe)
			status_bytes <= 56'h1 << ((i + 8) % 56);
			wt(2);
			`CHK("alert open", 1'b1, alert_pin_oe)
			`CHK("alert pull", 1'b0, alert_pin_out)
			status_bytes <= 56'h0;
		end
		$display("t_faults done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		wt(5);
		rst_b <= 1'b1;
		t_regs;
		t_pgood;
		t_ramp;
		t_faults;
		tally_and_finish;
	end
	initial
	begin
		wt(20000);
		fails++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
